// [dmm_defines.svh]
// register offsets, field masks and reset values of the dma channel
// assumes inclusion by bare name from the package and the channel module
`ifndef DMM_DEFINES_SVH
`define DMM_DEFINES_SVH
`define DMM_OFS_CFG 12'h000
`define DMM_OFS_CNT 12'h004
`define DMM_OFS_PBASE 12'h008
`define DMM_OFS_MBASE 12'h00C
`define DMM_OFS_STAT 12'h010
`define DMM_OFS_CLR 12'h014
`define DMM_OFS_IEN 12'h018
`define DMM_CFG_WMASK 32'h00004FE3
`define DMM_CFG_RST 32'h00000000
`define DMM_CNT_RST 16'h0000
`define DMM_ADDR_RST 32'h00000000
`define DMM_ST_HALF 0
`define DMM_ST_DONE 1
`define DMM_SZ_BYTE 2'h0
`define DMM_SZ_HALF 2'h1
`define DMM_SZ_WORD 2'h2
`endif

// [dmm_pkg.sv]
// types shared by the dma channel and its surroundings
// assumes the defines header for sizes and offsets
`include "dmm_defines.svh"
package dmm_pkg;
  // channel configuration word, bit 0 upward: en, dir, circular_select, incs, sizes, m2m
  typedef struct packed {
    logic [16:0] rsv_hi;
    logic mem_to_mem_select;
    logic [1:0] rsv_mid;
    logic [1:0] memory_size_field;
    logic [1:0] periph_size_field;
    logic memory_addr_increment;
    logic periph_addr_increment;
    logic circular_select;
    logic [2:0] rsv_lo;
    logic dir_mem_to_periph;
    logic enable;
  } dmm_cfg_t;
  // one request on the system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmm_breq_t;
  // gray along idle, read, write, stop
  typedef enum logic [1:0] {
    DMM_IDLE = 2'h0,
    DMM_RD = 2'h1,
    DMM_WR = 2'h3,
    DMM_STOP = 2'h2
  } dmm_state_t;
endpackage : dmm_pkg

// [dmm_channel.sv]
// one dma channel: apb register slave, system bus master, item width fitting
// assumes a bus slave that holds ready low until it takes a request,
// and a peripheral request on the same clock that drops once acknowledged
//
// Summary of operation
// - with memory-to-memory set the channel starts as soon as it is enabled with a nonzero count.
// - with circular off, memory-to-memory runs items back to back until the count is zero.
// - items are refitted when source and destination widths differ.
// - with increments on, each address steps by its own port width.
// - byte to halfword writes the byte with a zero upper byte.
// - byte to word writes the byte with three zero upper bytes.
// - halfword to byte writes only the low byte.
// - halfword to word writes the halfword with a zero upper half.
// - word to byte writes only the low byte.
// - equal widths copy the item unchanged.
// - each item is one read then one write.
// - halfword to byte steps source by two and destination by one.
// - the count drops by one per item and the bases stay untouched.
// - half and done flags set at half and end, raising enabled interrupts.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "dmm_defines.svh"
module dmm_channel (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output var dmm_pkg::dmm_breq_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ready,
  input wire logic periph_req,
  output logic periph_ack,
  output logic irq
);
  import dmm_pkg::*;

  dmm_cfg_t cfg_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_init_r;
  logic [31:0] pbase_r;
  logic [31:0] mbase_r;
  logic [31:0] pcur_r;
  logic [31:0] mcur_r;
  logic [31:0] data_r;
  logic [1:0] stat_r;
  logic [1:0] ien_r;
  logic ack_r;
  dmm_state_t state_r;
  dmm_state_t state_nxt;
  logic wr_acc;
  logic rd_done;
  logic item_done;
  logic start;
  logic [1:0] src_sz;
  logic [1:0] dst_sz;
  logic [31:0] src_addr;
  logic [31:0] dst_addr;
  logic [15:0] cnt_nxt;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;

  // byte count of one item of the given size
  function automatic logic [31:0] sz_bytes(input logic [1:0] sz);
    case (sz)
      `DMM_SZ_BYTE: sz_bytes = 32'h00000001;
      `DMM_SZ_HALF: sz_bytes = 32'h00000002;
      default: sz_bytes = 32'h00000004;
    endcase
  endfunction : sz_bytes

  // lanes that an item of the given size fills
  function automatic logic [31:0] sz_mask(input logic [1:0] sz);
    case (sz)
      `DMM_SZ_BYTE: sz_mask = 32'h000000FF;
      `DMM_SZ_HALF: sz_mask = 32'h0000FFFF;
      default: sz_mask = 32'hFFFFFFFF;
    endcase
  endfunction : sz_mask

  // apb decode; access phase always completes in its first cycle
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h00000000;
    case (paddr)
      `DMM_OFS_CFG: prdata = cfg_r;
      `DMM_OFS_CNT: prdata = {16'h0000, cnt_r};
      `DMM_OFS_PBASE: prdata = pbase_r;
      `DMM_OFS_MBASE: prdata = mbase_r;
      `DMM_OFS_STAT: prdata = {30'h00000000, stat_r};
      `DMM_OFS_CLR: prdata = 32'h00000000;
      `DMM_OFS_IEN: prdata = {30'h00000000, ien_r};
      default: pslverr = psel && penable;
    endcase
  end

  // configuration; reserved bits are masked so they read back as zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_r <= `DMM_CFG_RST;
    end else if (wr_acc && paddr == `DMM_OFS_CFG) begin
      cfg_r <= pwdata & `DMM_CFG_WMASK;
    end
  end

  // base addresses stay as programmed while current copies advance
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pbase_r <= `DMM_ADDR_RST;
      mbase_r <= `DMM_ADDR_RST;
    end else if (wr_acc && !cfg_r.enable) begin
      if (paddr == `DMM_OFS_PBASE) pbase_r <= pwdata;
      if (paddr == `DMM_OFS_MBASE) mbase_r <= pwdata;
    end
  end

  // port roles follow the direction bit, mem-to-mem included
  assign src_sz = cfg_r.dir_mem_to_periph ? cfg_r.memory_size_field : cfg_r.periph_size_field;
  assign dst_sz = cfg_r.dir_mem_to_periph ? cfg_r.periph_size_field : cfg_r.memory_size_field;
  assign src_addr = cfg_r.dir_mem_to_periph ? mcur_r : pcur_r;
  assign dst_addr = cfg_r.dir_mem_to_periph ? pcur_r : mcur_r;
  assign rd_done = state_r == DMM_RD && bus_ready;
  assign item_done = state_r == DMM_WR && bus_ready;
  assign cnt_nxt = cnt_r - 16'h0001;

  // request wait only outside mem-to-mem; a held request is not re-served
  assign start = cfg_r.enable && cnt_r != 16'h0000 &&
    (cfg_r.mem_to_mem_select || (periph_req && !ack_r));

  // item sequencer: one read then one write per item
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DMM_IDLE: if (start) state_nxt = DMM_RD;
      DMM_RD: if (bus_ready) state_nxt = DMM_WR;
      DMM_WR: begin
        if (bus_ready) begin
          if (cnt_nxt == 16'h0000 && !cfg_r.circular_select) begin
            state_nxt = DMM_STOP;
          end else if (cfg_r.mem_to_mem_select) begin
            state_nxt = DMM_RD;
          end else begin
            state_nxt = DMM_IDLE;
          end
        end
      end
      DMM_STOP: if (!cfg_r.enable) state_nxt = DMM_IDLE;
      default: state_nxt = DMM_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= DMM_IDLE;
    end else if (!cfg_r.enable && state_r != DMM_STOP) begin
      state_r <= DMM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // count reloads only while disabled; circular reloads the first value
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_r <= `DMM_CNT_RST;
      cnt_init_r <= `DMM_CNT_RST;
    end else if (wr_acc && paddr == `DMM_OFS_CNT && !cfg_r.enable) begin
      cnt_r <= pwdata[15:0];
      cnt_init_r <= pwdata[15:0];
    end else if (item_done) begin
      if (cnt_nxt == 16'h0000 && cfg_r.circular_select) begin
        cnt_r <= cnt_init_r;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // current addresses track the bases while disabled, so item one uses them
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pcur_r <= `DMM_ADDR_RST;
      mcur_r <= `DMM_ADDR_RST;
    end else if (!cfg_r.enable || (item_done && cnt_nxt == 16'h0000 && cfg_r.circular_select)) begin
      pcur_r <= pbase_r;
      mcur_r <= mbase_r;
    end else if (item_done) begin
      // each port steps by its own width
      if (cfg_r.periph_addr_increment) pcur_r <= pcur_r + sz_bytes(cfg_r.periph_size_field);
      if (cfg_r.memory_addr_increment) mcur_r <= mcur_r + sz_bytes(cfg_r.memory_size_field);
    end
  end

  // latch the item on the read, cut to the narrower of the two widths;
  // narrowing and zero extension are both a mask by the smaller size
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_r <= 32'h00000000;
    end else if (rd_done) begin
      data_r <= bus_rdata & sz_mask(src_sz) & sz_mask(dst_sz);
    end
  end

  // bus request held steady until ready; no lane duplication here
  always_comb begin
    bus_req.valid = state_r == DMM_RD || state_r == DMM_WR;
    bus_req.write = state_r == DMM_WR;
    bus_req.size = (state_r == DMM_WR) ? dst_sz : src_sz;
    bus_req.addr = (state_r == DMM_WR) ? dst_addr : src_addr;
    bus_req.wdata = (state_r == DMM_WR) ? data_r : 32'h00000000;
  end

  // acknowledge held until the peripheral drops its request
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else if (item_done && !cfg_r.mem_to_mem_select) begin
      ack_r <= 1'b1;
    end else if (!periph_req || cfg_r.mem_to_mem_select) begin
      ack_r <= 1'b0;
    end
  end
  assign periph_ack = ack_r && !cfg_r.mem_to_mem_select;

  // sticky flags: a set in the clearing cycle wins
  assign ev_set[`DMM_ST_HALF] = item_done && cnt_nxt == (cnt_init_r >> 1);
  assign ev_set[`DMM_ST_DONE] = item_done && cnt_nxt == 16'h0000;
  assign ev_clr = (wr_acc && paddr == `DMM_OFS_CLR) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= (stat_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ien_r <= 2'h0;
    end else if (wr_acc && paddr == `DMM_OFS_IEN) begin
      ien_r <= pwdata[1:0];
    end
  end
  assign irq = |(stat_r & ien_r);

  // checks next to the logic they guard
  a_m2m_start: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == DMM_IDLE && cfg_r.enable && cfg_r.mem_to_mem_select && cnt_r != 16'h0000)
    |=> state_r == DMM_RD) else $error("m2m did not start");
  a_no_read_zero: assert property (@(posedge clock) disable iff (!nrst)
    state_r == DMM_RD |-> cnt_r != 16'h0000) else $error("read with zero count");
  a_stop_hold: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == DMM_STOP && cfg_r.enable) |=> !bus_req.valid && state_r == DMM_STOP)
    else $error("ran after count zero");
  a_cnt_step: assert property (@(posedge clock) disable iff (!nrst)
    (item_done && cfg_r.enable && cnt_r > 16'h0001) |=> cnt_r == $past(cnt_r) - 16'h0001)
    else $error("count did not drop by one");
  a_byte_src_zext: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == DMM_WR && src_sz == `DMM_SZ_BYTE) |-> bus_req.wdata[31:8] == 24'h000000)
    else $error("byte source not zero extended");
  a_half_src_zext: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == DMM_WR && src_sz == `DMM_SZ_HALF) |-> bus_req.wdata[31:16] == 16'h0000)
    else $error("half source not zero extended");
  a_byte_dst_cut: assert property (@(posedge clock) disable iff (!nrst)
    (rd_done && dst_sz == `DMM_SZ_BYTE) |=> bus_req.wdata == {24'h000000, $past(bus_rdata[7:0])})
    else $error("byte destination not narrowed");
  a_equal_copy: assert property (@(posedge clock) disable iff (!nrst)
    (rd_done && src_sz == dst_sz) |=> bus_req.wdata == ($past(bus_rdata) & sz_mask(dst_sz)))
    else $error("equal widths altered data");
  a_read_then_write: assert property (@(posedge clock) disable iff (!nrst)
    (rd_done && cfg_r.enable) |=> bus_req.valid && bus_req.write)
    else $error("no write after read");
  // both ports checked in either direction; a config rewrite on that edge is exempt
  a_mem_step: assert property (@(posedge clock) disable iff (!nrst)
    (item_done && cfg_r.enable && cfg_r.memory_addr_increment && cnt_r > 16'h0001 &&
      !(wr_acc && paddr == `DMM_OFS_CFG))
    |=> mcur_r == $past(mcur_r) + sz_bytes(cfg_r.memory_size_field))
    else $error("memory address step wrong");
  a_periph_step: assert property (@(posedge clock) disable iff (!nrst)
    (item_done && cfg_r.enable && cfg_r.periph_addr_increment && cnt_r > 16'h0001 &&
      !(wr_acc && paddr == `DMM_OFS_CFG))
    |=> pcur_r == $past(pcur_r) + sz_bytes(cfg_r.periph_size_field))
    else $error("peripheral address step wrong");
  a_done_flag: assert property (@(posedge clock) disable iff (!nrst)
    (item_done && cfg_r.enable && cnt_r == 16'h0001 && !cfg_r.circular_select)
    |=> stat_r[`DMM_ST_DONE] && state_r == DMM_STOP)
    else $error("done flag or stop missing");
  a_irq_tie: assert property (@(posedge clock) disable iff (!nrst)
    (item_done && cnt_r == 16'h0001 && ien_r[`DMM_ST_DONE] &&
      !(wr_acc && paddr == `DMM_OFS_IEN))
    |=> irq) else $error("done interrupt not raised");
  a_bus_hold: assert property (@(posedge clock) disable iff (!nrst)
    (bus_req.valid && !bus_ready && cfg_r.enable && !(wr_acc && paddr == `DMM_OFS_CFG))
    |=> $stable(bus_req)) else $error("bus request changed before ready");
  a_m2m_no_ack: assert property (@(posedge clock) disable iff (!nrst)
    (cfg_r.mem_to_mem_select && $past(cfg_r.mem_to_mem_select)) |-> !ack_r && !periph_ack)
    else $error("ack in m2m");
endmodule : dmm_channel
`default_nettype wire

// [dmm_bus_mem_model.sv]
// system bus memory model on the far side of the dma channel
// assumes one request held until ready; read items come back in low lanes
`timescale 1ns/1ns
`default_nettype none
module dmm_bus_mem_model (
  input wire logic clock,
  input wire logic nrst,
  input wire dmm_pkg::dmm_breq_t bus_req,
  input wire logic [1:0] wait_cycles,
  output logic [31:0] bus_rdata,
  output logic bus_ready
);
  import dmm_pkg::*;
  logic [1:0] wait_cnt_r;
  dmm_breq_t log_q[$];
  // byte k of memory holds k*7+3; unused lanes carry junk so a missing mask shows
  function automatic logic [31:0] rd_item(input dmm_breq_t r);
    logic [31:0] v;
    v = 32'h5A5A5A5A;
    for (int i = 0; i < 4; i++) begin
      if (i < (1 << r.size)) v[8*i +: 8] = 8'((r.addr + i) * 7 + 3);
    end
    return v;
  endfunction : rd_item
  // answer after wait_cycles, log each taken request; idle data toggles
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wait_cnt_r <= 2'h0;
      bus_ready <= 1'b0;
      bus_rdata <= 32'h0;
    end else if (bus_ready) begin
      bus_ready <= 1'b0;
      wait_cnt_r <= 2'h0;
      bus_rdata <= ~bus_rdata;
    end else if (bus_req.valid && wait_cnt_r == wait_cycles) begin
      bus_ready <= 1'b1;
      bus_rdata <= bus_req.write ? ~bus_rdata : rd_item(bus_req);
    end else begin
      wait_cnt_r <= bus_req.valid ? wait_cnt_r + 2'h1 : 2'h0;
      bus_rdata <= ~bus_rdata;
    end
  end
  // log kept in its own process, the bench empties it between tests
  always @(posedge clock) begin
    if (nrst && bus_ready) log_q.push_back(bus_req);
  end
endmodule : dmm_bus_mem_model
`default_nettype wire

// [dmm_channel_bench.sv]
// self-checking bench: apb programs memory-to-memory copies of all widths
// assumes zero-wait apb and the bus memory model on the far side
`timescale 1ns/1ns
`default_nettype none
`include "dmm_defines.svh"
module dmm_channel_bench;
  import dmm_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic periph_req = 1'b0;
  logic [1:0] wait_cycles = 2'h0;
  logic [31:0] prdata, bus_rdata;
  logic pready, pslverr, bus_ready, periph_ack, irq;
  logic ack_seen = 1'b0;
  dmm_breq_t bus_req;
  int mismatches = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  dmm_channel dmm_channel_i (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_req, .bus_rdata, .bus_ready, .periph_req,
    .periph_ack, .irq);
  dmm_bus_mem_model dmm_bus_mem_model_i (.clock, .nrst, .bus_req, .wait_cycles,
    .bus_rdata, .bus_ready);
  // any acknowledge at all is wrong, the bench only runs memory-to-memory
  always @(posedge clock) begin
    if (nrst && periph_ack !== 1'b0) ack_seen <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // hang guard, far beyond nine short copies
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end
  // main sequence: reset values, then every source/destination width pair
  initial begin
    logic [31:0] q, ex, sbase, dbase;
    logic e;
    int n, sb, db, m, dr;
    dmm_breq_t r, w;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    rd(`DMM_OFS_CFG, q); check(q, `DMM_CFG_RST);
    rd(`DMM_OFS_CNT, q); check(q, 32'h0);
    rd(`DMM_OFS_STAT, q); check(q, 32'h0);
    apb(1'b0, 12'h01C, 32'h0, q, e); check(32'(e), 32'h1);
    $display("reset test done");
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 3; d++) begin
        n = s * 3 + d;
        sb = 1 << s;
        db = 1 << d;
        m = sb < db ? sb : db;
        dr = n[0] ? 0 : 1;
        sbase = dr ? 32'h10 : 32'h80;
        dbase = dr ? 32'h80 : 32'h10;
        wait_cycles <= 2'(n % 3); // slow and prompt answers
        periph_req <= n[0]; // request level must not matter
        dmm_bus_mem_model_i.log_q.delete();
        wr(`DMM_OFS_MBASE, 32'h10);
        wr(`DMM_OFS_PBASE, 32'h80);
        wr(`DMM_OFS_CNT, 32'h4);
        wr(`DMM_OFS_IEN, 32'(n % 4));
        // m2m, both increments, circular off even tests read the memory port
        if (dr) wr(`DMM_OFS_CFG, 32'h40C3 | (d << 8) | (s << 10));
        else wr(`DMM_OFS_CFG, 32'h40C1 | (s << 8) | (d << 10));
        q = 32'h0;
        for (int k = 0; k < 100 && !q[1]; k++) rd(`DMM_OFS_STAT, q);
        repeat (20) @(posedge clock);
        check(dmm_bus_mem_model_i.log_q.size(), 8);
        for (int i = 0; i < 4; i++) begin
          r = dmm_bus_mem_model_i.log_q[2*i];
          w = dmm_bus_mem_model_i.log_q[2*i+1];
          ex = 32'h0;
          for (int b = 0; b < m; b++) ex[8*b +: 8] = 8'((sbase + i * sb + b) * 7 + 3);
          check(32'({r.write, r.size, w.write, w.size}), 32'({3'(s), 1'b1, 2'(d)}));
          check(r.addr, 32'(sbase + i * sb));
          check(w.addr, 32'(dbase + i * db));
          check(w.wdata, ex);
        end
        rd(`DMM_OFS_CNT, q); check(q, 32'h0);
        rd(`DMM_OFS_PBASE, q); check(q, 32'h80);
        rd(`DMM_OFS_STAT, q); check(q, 32'h3);
        check(32'(irq), 32'((n % 4) != 0));
        wr(`DMM_OFS_CLR, 32'h3);
        rd(`DMM_OFS_STAT, q); check(q, 32'h0);
        check(32'(irq), 32'h0);
        wr(`DMM_OFS_CFG, 32'h0);
        $display("width test %0d done", n);
      end
    end
    check(32'(ack_seen), 32'h0);
    summarize();
  end
endmodule : dmm_channel_bench
`default_nettype wire
